// ==== logic/led_status_driver.sv ====
// LED status driver: four active-low pins per port for eight ports,
// plus the serial LED stream on port 0's first two pins.
// Assumes port status inputs arrive on ref_clk_i; registers are reached
// over a plain strobe port with read data one cycle later.
//
// Overview of operation
// - LED pins are active low
// - Mode 4: 100/1000 copper link with activity
// - Mode 5: 10/1000 copper link with activity
// - Mode 6: 10/100 copper link with activity
// - Mode 7: fibre link with activity
// - Mode 8: full duplex lit, collisions blink
// - Mode 9: collisions only
// - Mode 10: activity, optionally transmit only
// - Mode 11: fibre activity, optionally receive only
// - Mode 12: auto-negotiation fault lights pin
// - Mode 13 serial, only on port 0's first pin
// - Mode 14 forces off, 15 on
// - Fibre-disable makes link/activity copper only
// - Combine adds activity to primary status
// - Per pin blink or pulse-stretch choice
// - Selectable blink rates and stretch lengths
// - Pulsing at 5 kHz, 20 percent duty
// - Serial: pin 0 data, pin 1 clock
// - 96 bits, captured on rising clock
// - Serial bits use port's first pin behaviour
// - Port order and twelve-bit slot order
`timescale 1ns/1ns
`default_nettype none

module led_status_driver
	import led_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC,
	parameter int PWM_PER_CYCLES = PWM_PER_CYC,
	parameter int PWM_ON_CYCLES = PWM_ON_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DW-1:0] rdata_o,
	input wire logic [NPORT-1:0] link_i,
	input wire logic [2*NPORT-1:0] speed_i,
	input wire logic [NPORT-1:0] fibre_i,
	input wire logic [NPORT-1:0] fdx_i,
	input wire logic [NPORT-1:0] col_i,
	input wire logic [NPORT-1:0] tx_act_i,
	input wire logic [NPORT-1:0] rx_act_i,
	input wire logic [NPORT-1:0] an_fault_i,
	output logic [NPORT*NLED-1:0] led_n_o
);

	typedef enum logic [1:0] {SER_GAP, SER_LOW, SER_HIGH} ser_st_t;

	// Register group of an address
	function automatic logic [1:0] grp(input logic [AW-1:0] a);
		grp = a[4:3];
	endfunction

	// Whether a pin or serial bit is lit for a display code
	function automatic logic led_lit(
		input logic [4:0] code,
		input logic lnk,
		input logic fib,
		input logic [1:0] spd,
		input logic fdx,
		input logic anf,
		input logic comb,
		input logic [3:0] m,
		input logic txrx,
		input logic fiboff
	);
		logic cu;
		logic base;
		logic sec;
		cu = lnk & ~fib;
		sec = comb & m[S_ANY]; // Activity darkens a lit link
		base = 1'b0;
		led_lit = 1'b0;
		unique case (code)
			C_LNKACT: base = lnk & ~(fib & fiboff);
			C_L1000: base = cu & (spd == SPD_1000);
			C_L100: base = cu & (spd == SPD_100);
			C_L10: base = cu & (spd == SPD_10);
			C_L100G: base = cu & (spd != SPD_10);
			C_L10G: base = cu & (spd != SPD_100);
			C_L10100: base = cu & (spd != SPD_1000);
			C_FIB: base = lnk & fib;
			default: base = 1'b0;
		endcase
		unique case (code)
			C_LNKACT, C_L1000, C_L100, C_L10, C_L100G, C_L10G, C_L10100, C_FIB: begin
				led_lit = base & ~sec;
			end
			C_DPX: begin
				// Half duplex only shows up while colliding
				led_lit = (lnk & fdx) | (comb & lnk & ~fdx & m[S_COL]);
			end
			C_COL: led_lit = m[S_COL];
			C_ACT: led_lit = txrx ? m[S_TX] : m[S_ANY];
			C_FACT: led_lit = lnk & fib & (txrx ? m[S_RX] : m[S_ANY]);
			C_ANF: led_lit = anf;
			C_ON: led_lit = 1'b1;
			C_RX: led_lit = m[S_RX];
			C_TX: led_lit = m[S_TX];
			default: led_lit = 1'b0; // Off, reserved, serial elsewhere
		endcase
	endfunction

	// Display code of each serial slot within a port
	function automatic logic [4:0] slot_code(input logic [3:0] s);
		unique case (s)
			4'h0: slot_code = C_LNKACT;
			4'h1: slot_code = C_L1000;
			4'h2: slot_code = C_L100;
			4'h3: slot_code = C_L10;
			4'h5: slot_code = C_DPX;
			4'h6: slot_code = C_COL;
			4'h7: slot_code = C_ACT;
			4'h9: slot_code = C_TX;
			4'ha: slot_code = C_RX;
			4'hb: slot_code = C_ANF;
			default: slot_code = C_RSV; // Slots 4, 8 and unused codes
		endcase
	endfunction

	logic [DW-1:0] mode_q [NPORT]; // Four 4-bit pin modes per port
	logic [DW-1:0] beh_q [NPORT]; // Behaviour word per port
	logic [DW-1:0] rdata_q; // Read answer, one cycle only
	logic [16:0] ms_cnt_q; // Millisecond prescaler
	logic ms_tick; // One cycle per millisecond
	logic [8:0] blink_ms_q; // Position in the common blink frame
	logic [3:0] phase; // Blink phase per rate
	logic [14:0] pwm_cnt_q; // Pulsing period counter
	logic pwm_on; // Pulsing high part
	logic [NPORT-1:0][3:0] m_str; // Stretched activity
	logic [NPORT-1:0][3:0] m_blk; // Blinking activity
	logic [NPORT-1:0][3:0] m_ser; // Serial view, first pin's choice
	logic [NPORT*NLED-1:0] led_n_d; // Next pin levels
	logic [NPORT*NLED-1:0] led_n_q; // Registered pin levels
	ser_st_t ser_st_q; // Serial frame state
	logic [9:0] ser_cnt_q; // Half-period or gap counter
	logic [2:0] ser_port_q; // Port being sent
	logic [3:0] ser_slot_q; // Slot within the port
	logic ser_dat_q; // Held serial data level
	logic ser_en; // Port 0 pin 0 selects serial
	logic ser_lit; // Current serial bit lit
	logic ser_last; // Last slot of the last port

	assign rdata_o = rdata_q;
	assign led_n_o = led_n_q;

	// Software writes; unmapped and status addresses are ignored
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int p = 0; p < NPORT; p++) begin
				mode_q[p] <= MODE_RST;
				beh_q[p] <= BEH_RST;
			end
		end else if (ce_i && wr_i) begin
			if (grp(addr_i) == G_MODE) begin
				mode_q[addr_i[2:0]] <= wdata_i;
			end else if (grp(addr_i) == G_BEH) begin
				beh_q[addr_i[2:0]] <= wdata_i;
			end
		end
	end

	// Read answer stands for one cycle, zero otherwise
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else if (ce_i) begin
			rdata_q <= '0;
			if (rd_i) begin
				unique case (grp(addr_i))
					G_MODE: rdata_q <= mode_q[addr_i[2:0]];
					G_BEH: rdata_q <= beh_q[addr_i[2:0]];
					G_STAT: begin
						// Lit pins on top, raw status below
						rdata_q <= {~led_n_q[4*addr_i[2:0] +: 4], 3'h0,
							an_fault_i[addr_i[2:0]], rx_act_i[addr_i[2:0]],
							tx_act_i[addr_i[2:0]], col_i[addr_i[2:0]],
							fdx_i[addr_i[2:0]], fibre_i[addr_i[2:0]],
							speed_i[2*addr_i[2:0] +: 2], link_i[addr_i[2:0]]};
					end
					default: rdata_q <= '0; // Unmapped reads zero
				endcase
			end
		end
	end

	// Millisecond tick shared by blink and stretch timing
	assign ms_tick = (ms_cnt_q == 17'(MS_CYCLES - 1));
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ms_cnt_q <= '0;
		end else if (ce_i) begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 17'h1;
		end
	end

	// One frame covers a whole period of every blink rate
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			blink_ms_q <= '0;
		end else if (ce_i && ms_tick) begin
			if (blink_ms_q == 9'(BLINK_FRAME_MS - 1)) begin
				blink_ms_q <= '0;
			end else begin
				blink_ms_q <= blink_ms_q + 9'h1;
			end
		end
	end

	// 50 percent blink wave per rate
	for (genvar r = 0; r < 4; r++) begin : g_phase
		assign phase[r] = (int'(blink_ms_q) % (2 * BLINK_HALF_MS[r])) >= BLINK_HALF_MS[r];
	end

	// Pulsing wave, shared so all pins pulse in step
	assign pwm_on = (pwm_cnt_q < 15'(PWM_ON_CYCLES));
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pwm_cnt_q <= '0;
		end else if (ce_i) begin
			if (pwm_cnt_q == 15'(PWM_PER_CYCLES - 1)) begin
				pwm_cnt_q <= '0;
			end else begin
				pwm_cnt_q <= pwm_cnt_q + 15'h1;
			end
		end
	end

	// Per port activity shaping
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic [3:0] evt; // Raw events
		logic [1:0] rate; // Rate select of this port
		assign evt = {col_i[p], rx_act_i[p], tx_act_i[p], tx_act_i[p] | rx_act_i[p]};
		assign rate = beh_q[p][B_RATE +: 2];
		assign m_blk[p] = evt & {4{phase[rate]}};
		assign m_ser[p] = beh_q[p][B_STR] ? m_str[p] : m_blk[p];

		for (genvar s = 0; s < 4; s++) begin : g_src
			logic [8:0] cnt_q; // Remaining whole ms plus one
			logic on_q; // Stretched pulse active
			logic [8:0] len; // Length of each stretch phase
			// One extra ms covers the partial first millisecond
			assign len = 9'(STR_MS[rate]) + 9'h1;
			assign m_str[p][s] = on_q;
			// Holds on, then off, each for at least the chosen time
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					cnt_q <= '0;
					on_q <= 1'b0;
				end else if (ce_i) begin
					if (on_q) begin
						if (ms_tick) begin
							if (cnt_q <= 9'h1) begin
								on_q <= 1'b0;
								cnt_q <= len;
							end else begin
								cnt_q <= cnt_q - 9'h1;
							end
						end
					end else if (cnt_q != 9'h0) begin
						if (ms_tick) begin
							cnt_q <= cnt_q - 9'h1;
						end
					end else if (evt[s]) begin
						on_q <= 1'b1;
						cnt_q <= len;
					end
				end
			end
		end

		// Pin level per LED
		for (genvar l = 0; l < NLED; l++) begin : g_led
			logic lit; // Display says lit
			logic drive; // Lit after pulsing
			logic [3:0] m_led; // Activity seen by this pin
			assign m_led = beh_q[p][B_STR + l] ? m_str[p] : m_blk[p];
			assign lit = led_lit({1'b0, mode_q[p][4*l +: 4]}, link_i[p], fibre_i[p],
				speed_i[2*p +: 2], fdx_i[p], an_fault_i[p], beh_q[p][B_COMB + l],
				m_led, beh_q[p][B_TXRX], beh_q[p][B_FIBOFF]);
			assign drive = lit & (~beh_q[p][B_PULSE] | pwm_on);
			if (p == 0 && l == 0) begin : g_dat
				assign led_n_d[0] = ser_en ? ser_dat_q : ~drive;
			end else if (p == 0 && l == 1) begin : g_clk
				assign led_n_d[1] = ser_en ? (ser_st_q == SER_HIGH) : ~drive;
			end else begin : g_pin
				// Serial code elsewhere falls to off in the display table
				assign led_n_d[p*NLED + l] = ~drive;
			end
		end
	end

	// Registered pins, low means lit
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			led_n_q <= '1;
		end else if (ce_i) begin
			led_n_q <= led_n_d;
		end
	end

	// Serial bit for the current port and slot
	assign ser_en = (mode_q[0][3:0] == C_SER);
	assign ser_last = (ser_port_q == 3'h7) && (ser_slot_q == 4'(SER_SLOTS - 1));
	assign ser_lit = led_lit(slot_code(ser_slot_q), link_i[ser_port_q], fibre_i[ser_port_q],
		speed_i[2*ser_port_q +: 2], fdx_i[ser_port_q], an_fault_i[ser_port_q],
		beh_q[ser_port_q][B_COMB], m_ser[ser_port_q], 1'b0,
		beh_q[ser_port_q][B_FIBOFF]);

	// Serial frame: gap, then 96 bits of low and high clock halves
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ser_st_q <= SER_GAP;
			ser_cnt_q <= '0;
			ser_port_q <= '0;
			ser_slot_q <= '0;
			ser_dat_q <= 1'b1;
		end else if (ce_i) begin
			unique case (ser_st_q)
				SER_GAP: begin
					// Idle: clock low, data high
					ser_dat_q <= 1'b1;
					if (ser_cnt_q == 10'(SER_GAP_CYC - 1)) begin
						ser_cnt_q <= '0;
						ser_st_q <= SER_LOW;
					end else begin
						ser_cnt_q <= ser_cnt_q + 10'h1;
					end
				end
				SER_LOW: begin
					// Data is latched once so it cannot move under the rising edge
					if (ser_cnt_q == 10'h0) begin
						ser_dat_q <= ~ser_lit;
					end
					if (ser_cnt_q == 10'(SER_HALF_CYC - 1)) begin
						ser_cnt_q <= '0;
						ser_st_q <= SER_HIGH;
					end else begin
						ser_cnt_q <= ser_cnt_q + 10'h1;
					end
				end
				SER_HIGH: begin
					if (ser_cnt_q == 10'(SER_HALF_CYC - 1)) begin
						ser_cnt_q <= '0;
						if (ser_last) begin
							ser_port_q <= '0;
							ser_slot_q <= '0;
							ser_st_q <= SER_GAP;
						end else begin
							ser_st_q <= SER_LOW;
							if (ser_slot_q == 4'(SER_SLOTS - 1)) begin
								ser_slot_q <= '0;
								ser_port_q <= ser_port_q + 3'h1;
							end else begin
								ser_slot_q <= ser_slot_q + 4'h1;
							end
						end
					end else begin
						ser_cnt_q <= ser_cnt_q + 10'h1;
					end
				end
				default: ser_st_q <= SER_GAP; // Unused encoding
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== pkg/led_pkg.sv ====
// Constants shared by the LED status driver: register map, fields,
// display codes and timing counts.
// Assumes a 125 MHz core clock; holds definitions only.
package led_pkg;
	localparam int NPORT = 8; // Ports
	localparam int NLED = 4; // Pins per port
	localparam int DW = 16; // Register data width
	localparam int AW = 5; // Register address width
	// Register groups, selected by address bits [4:3]
	localparam logic [1:0] G_MODE = 2'h0; // 0x00-0x07 pin modes
	localparam logic [1:0] G_BEH = 2'h1; // 0x08-0x0f behaviour
	localparam logic [1:0] G_STAT = 2'h2; // 0x10-0x17 port status
	// Behaviour word fields
	localparam int B_COMB = 0; // [3:0] combine per pin
	localparam int B_STR = 4; // [7:4] stretch instead of blink
	localparam int B_RATE = 8; // [9:8] rate select
	localparam int B_PULSE = 12; // Low-duty pulsing
	localparam int B_TXRX = 14; // Tx-only or rx-only activity
	localparam int B_FIBOFF = 15; // Copper-only link/activity
	localparam logic [15:0] MODE_RST = 16'h8a10;
	localparam logic [15:0] BEH_RST = 16'h000f;
	// Speed codes from the port cores
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	// Display codes: 0-15 are pin modes, above are serial-only
	localparam logic [4:0] C_LNKACT = 5'h00;
	localparam logic [4:0] C_L1000 = 5'h01;
	localparam logic [4:0] C_L100 = 5'h02;
	localparam logic [4:0] C_L10 = 5'h03;
	localparam logic [4:0] C_L100G = 5'h04;
	localparam logic [4:0] C_L10G = 5'h05;
	localparam logic [4:0] C_L10100 = 5'h06;
	localparam logic [4:0] C_FIB = 5'h07;
	localparam logic [4:0] C_DPX = 5'h08;
	localparam logic [4:0] C_COL = 5'h09;
	localparam logic [4:0] C_ACT = 5'h0a;
	localparam logic [4:0] C_FACT = 5'h0b;
	localparam logic [4:0] C_ANF = 5'h0c;
	localparam logic [3:0] C_SER = 4'hd;
	localparam logic [4:0] C_OFF = 5'h0e;
	localparam logic [4:0] C_ON = 5'h0f;
	localparam logic [4:0] C_RX = 5'h10;
	localparam logic [4:0] C_TX = 5'h11;
	localparam logic [4:0] C_RSV = 5'h12;
	// Activity source indices
	localparam int S_ANY = 0;
	localparam int S_TX = 1;
	localparam int S_RX = 2;
	localparam int S_COL = 3;
	// Timing
	localparam int CLK_NS = 8; // Core clock period
	localparam int MS_NS = 1000000; // One millisecond
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int PWM_PER_NS = 200000; // 5 kHz period
	localparam int PWM_ON_NS = 40000; // 20 percent of it
	localparam int PWM_PER_CYC = PWM_PER_NS / CLK_NS;
	localparam int PWM_ON_CYC = PWM_ON_NS / CLK_NS;
	localparam int BLINK_FRAME_MS = 400; // Common multiple of all blink periods
	localparam int BLINK_HALF_MS [4] = '{200, 100, 50, 25}; // 2.5/5/10/20 Hz
	localparam int STR_MS [4] = '{50, 100, 200, 400}; // Stretch lengths
	localparam int SER_HALF_NS = 256; // Serial clock half period
	localparam int SER_HALF_CYC = SER_HALF_NS / CLK_NS;
	localparam int SER_GAP_NS = 8000; // Idle gap between frames
	localparam int SER_GAP_CYC = SER_GAP_NS / CLK_NS;
	localparam int SER_SLOTS = 12; // Serial bits per port
endpackage

// ==== test/led_shift_board.sv ====
// Model of an external shift-register LED board on the serial stream.
// Assumes data and clock come from port 0's first two pins.
`timescale 1ns/1ns
`default_nettype none
module led_shift_board (
	input wire logic sdata_i,
	input wire logic sclk_i,
	output logic [95:0] frame_o,
	output int frames_o
);
	logic [95:0] sh; // Bits as they arrive
	int idx = 0; // Next bit slot
	realtime last_t = 0; // Previous clock rise
	initial begin
		frame_o = '0;
		frames_o = 0;
		sh = '0;
	end
	// Capture on the rising clock; a long quiet spell starts a new frame
	always @(posedge sclk_i) begin
		if ($realtime - last_t > 2000)
			idx = 0;
		last_t = $realtime;
		sh[idx] = sdata_i;
		idx = idx + 1;
		if (idx == 96) begin
			frame_o = sh;
			frames_o = frames_o + 1;
			idx = 0;
		end
	end
endmodule
`default_nettype wire

// ==== test/led_status_chk.sv ====
// Port-level assertions for the LED status driver.
// Assumes it is bound into led_status_driver; a shadow of port 0 registers.
`timescale 1ns/1ns
`default_nettype none
module led_status_chk
	import led_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DW-1:0] rdata_o,
	input wire logic [NPORT-1:0] an_fault_i,
	input wire logic [NPORT*NLED-1:0] led_n_o
);
	logic [DW-1:0] mode0_q; // Port 0 mode word copy
	logic pulse0_q; // Port 0 pulsing bit copy
	logic ser; // Serial stream selected
	assign ser = mode0_q[3:0] == C_SER;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Shadow copies, so pin checks know the mode without looking inside
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mode0_q <= MODE_RST;
			pulse0_q <= BEH_RST[B_PULSE];
		end else if (ce_i && wr_i && addr_i == 5'h00) begin
			mode0_q <= wdata_i;
		end else if (ce_i && wr_i && addr_i == 5'h08) begin
			pulse0_q <= wdata_i[B_PULSE];
		end
	end
	// Reset must not be masked here, hence no disable
	a_reset_dark: assert property (disable iff (1'b0) rst_i |=> led_n_o == '1)
		else $error("pins not dark after reset");
	a_unmapped_zero: assert property (ce_i && rd_i && addr_i[4:3] == 2'h3 |=> rdata_o == '0)
		else $error("unmapped read not zero");
	a_mode_readback: assert property (ce_i && wr_i && !addr_i[4] ##2 ce_i && rd_i
		&& addr_i == $past(addr_i, 2) |=> rdata_o == $past(wdata_i, 3))
		else $error("register read back differs");
	a_force_off: assert property (ce_i && wr_i && addr_i == 5'h00 && wdata_i[11:8] == 4'he
		##1 ce_i && !wr_i |=> led_n_o[2])
		else $error("forced off pin lit");
	a_force_on: assert property (ce_i && wr_i && addr_i == 5'h00 && wdata_i[15:12] == 4'hf
		&& !pulse0_q ##1 ce_i && !wr_i |=> !led_n_o[3])
		else $error("forced on pin dark");
	a_fault_pin: assert property ((ce_i && mode0_q[3:0] == 4'hc && !pulse0_q
		&& $stable(an_fault_i[0]))[*3] |-> led_n_o[0] == !an_fault_i[0])
		else $error("fault pin wrong");
	a_sclk_low: assert property (ser && $past(ser, 3) && $fell(led_n_o[1])
		|-> ##31 (!led_n_o[1] || !ser))
		else $error("serial clock low phase short");
	a_sdata_hold: assert property (ser && $past(ser, 3) && $rose(led_n_o[1])
		|=> (!ser || $stable(led_n_o[0]))[*8])
		else $error("serial data moved after rising clock");
endmodule

bind led_status_driver led_status_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .an_fault_i(an_fault_i), .led_n_o(led_n_o));
`default_nettype wire

// ==== test/test_led_status_driver.sv ====
// Self-checking bench: registers, pin modes, blink, pulsing, serial stream.
// Assumes 125 MHz clock; millisecond and pulsing counts are shortened.
`timescale 1ns/1ns
`default_nettype none
module test_led_status_driver;
	import led_pkg::*;
	localparam int MSC = 10; // Shortened millisecond
	logic ref_clk_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0;
	logic [AW-1:0] addr_i = '0;
	logic [DW-1:0] wdata_i = '0;
	logic [DW-1:0] rdata_o;
	logic [NPORT-1:0] link_i = '0, fibre_i = '0, fdx_i = '0, col_i = '0;
	logic [NPORT-1:0] tx_act_i = '0, rx_act_i = '0, an_fault_i = '0;
	logic [2*NPORT-1:0] speed_i = '0;
	logic [NPORT*NLED-1:0] led_n_o;
	logic [95:0] frame; // Last full frame on the board
	int frames, error_cnt = 0, num_checks = 0, c0, c1;
	logic [31:0] seed = 32'h14; // Fixed start of the random stream
	led_status_driver #(.MS_CYCLES(MSC), .PWM_PER_CYCLES(20), .PWM_ON_CYCLES(4)) uut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_i(link_i),
		.speed_i(speed_i), .fibre_i(fibre_i), .fdx_i(fdx_i), .col_i(col_i),
		.tx_act_i(tx_act_i), .rx_act_i(rx_act_i), .an_fault_i(an_fault_i),
		.led_n_o(led_n_o));
	led_shift_board board (.sdata_i(led_n_o[0]), .sclk_i(led_n_o[1]), .frame_o(frame),
		.frames_o(frames));
	initial begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected lit state of a pin of port p in mode m
	function automatic logic lit_of(input int m, input int p, input logic b15);
		logic l;
		logic [1:0] s;
		l = link_i[p];
		s = speed_i[2*p+:2];
		case (m)
		0: return l & ~(fibre_i[p] & b15);
		1: return l & ~fibre_i[p] & (s == SPD_1000);
		2: return l & ~fibre_i[p] & (s == SPD_100);
		3: return l & ~fibre_i[p] & (s == SPD_10);
		4: return l & ~fibre_i[p] & (s != SPD_10);
		5: return l & ~fibre_i[p] & (s != SPD_100);
		6: return l & ~fibre_i[p] & (s != SPD_1000);
		7: return l & fibre_i[p];
		8: return l & fdx_i[p];
		12: return an_fault_i[p];
		15: return 1'b1;
		default: return 1'b0;
		endcase
	endfunction
	// Expected serial frame, copper links, no activity; active low
	function automatic logic [95:0] ser_exp();
		logic [95:0] f;
		logic [1:0] s;
		logic l;
		for (int p = 0; p < NPORT; p++) begin
			s = speed_i[2*p+:2];
			l = link_i[p];
			f[12*p+:12] = ~{an_fault_i[p], 5'h00, l & fdx_i[p], 1'b0, l & (s == SPD_10),
				l & (s == SPD_100), l & (s == SPD_1000), l};
		end
		return f;
	endfunction
	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 check(96'(rdata_o), 96'(exp));
	endtask
	// Same mode and behaviour word into every port
	task automatic modes(input logic [DW-1:0] mw, input logic [DW-1:0] bw);
		for (int p = 0; p < NPORT; p++) begin
			wr(5'(p), mw);
			wr(5'(8 + p), bw);
		end
	endtask
	// New random status; pins follow one edge later
	task automatic set_status(input logic fib);
		logic [2*NPORT-1:0] sp;
		for (int p = 0; p < NPORT; p++)
			sp[2*p+:2] = 2'(rnd() % 3);
		@(posedge ref_clk_i);
		speed_i <= sp;
		link_i <= 8'(rnd());
		fibre_i <= fib ? 8'(rnd()) : 8'h00;
		fdx_i <= 8'(rnd());
		an_fault_i <= 8'(rnd());
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask
	// Lit cycles of port 1 pins 0 and 1 over n cycles
	task automatic count(input int n);
		c0 = 0;
		c1 = 0;
		repeat (n) begin
			@(posedge ref_clk_i);
			#1;
			c0 += int'(!led_n_o[4]);
			c1 += int'(!led_n_o[5]);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		int f0;
		logic b15;
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		#1 check(96'(led_n_o), 96'hffffffff);
		rd(5'h00, MODE_RST);
		rd(5'h08, BEH_RST);
		rd(5'h18, 16'h0000);
		// Every pin mode against random status, fibre toggling copper-only
		for (int i = 0; i < 16; i++) begin
			b15 = rnd() % 2 == 1;
			modes({4{4'(i)}}, {b15, 15'h0000});
			rd(5'h0f, {b15, 15'h0000});
			repeat (6) begin
				set_status(1'b1);
				for (int k = 0; k < 32; k++)
					if (!(i == 13 && k < 2))
						check(96'(led_n_o[k]), 96'(!lit_of(i, k / 4, b15)));
			end
		end
		// Transmit-only activity ignores receive traffic
		@(posedge ref_clk_i);
		link_i <= '1;
		col_i <= '1;
		rx_act_i <= '1;
		modes(16'h009a, 16'h4000);
		count(4000);
		check(96'(c0), 96'(0));
		@(posedge ref_clk_i);
		tx_act_i <= '1;
		for (int r = 0; r < 4; r++) begin
			modes(16'h009a, 16'h4000 | 16'(r << 8));
			count(2 * BLINK_HALF_MS[r] * MSC);
			check(96'(c0), 96'(BLINK_HALF_MS[r] * MSC));
			check(96'(c1), 96'(BLINK_HALF_MS[r] * MSC));
		end
		modes(16'hffff, 16'h1000);
		count(20);
		check(96'(c0), 96'(4));
		// Clock enable low freezes the pulsing pin at one level
		@(posedge ref_clk_i);
		ce_i <= 1'b0;
		count(20);
		check(96'(c0 == 0 || c0 == 20), 96'(1));
		@(posedge ref_clk_i);
		ce_i <= 1'b1;
		// Fibre receive-only activity and half-duplex collisions, fastest blink
		fibre_i <= '1;
		fdx_i <= '0;
		modes(16'h008b, 16'h4302);
		count(2 * BLINK_HALF_MS[3] * MSC);
		check(96'(c0), 96'(BLINK_HALF_MS[3] * MSC));
		check(96'(c1), 96'(BLINK_HALF_MS[3] * MSC));
		// No receive traffic: fibre pin dark; full duplex: duplex pin steady
		@(posedge ref_clk_i);
		rx_act_i <= '0;
		fdx_i <= '1;
		count(2 * BLINK_HALF_MS[3] * MSC);
		check(96'(c0), 96'(0));
		check(96'(c1), 96'(2 * BLINK_HALF_MS[3] * MSC));
		// Link 1000 with activity: steady without combine, blinking with it
		@(posedge ref_clk_i);
		speed_i <= {8{SPD_1000}};
		fibre_i <= '0;
		modes(16'h0004, 16'h0000);
		count(4000);
		check(96'(c0), 96'(4000));
		modes(16'h0004, 16'h0001);
		count(4000);
		check(96'(c0), 96'(2000));
		// Serial stream into the board model
		@(posedge ref_clk_i);
		col_i <= '0;
		tx_act_i <= '0;
		rx_act_i <= '0;
		set_status(1'b0);
		modes(16'h000d, 16'h0000);
		f0 = frames;
		for (int t = 0; t < 25000 && frames < f0 + 2; t++)
			@(posedge ref_clk_i);
		check(96'(frames >= f0 + 2), 96'(1));
		check(frame, ser_exp());
		// Status word of port 1: serial code dark off port 0, link/activity lit
		rd(5'h11, {{3{link_i[1]}}, 1'b0, 3'h0, an_fault_i[1], rx_act_i[1], tx_act_i[1],
			col_i[1], fdx_i[1], fibre_i[1], speed_i[3:2], link_i[1]});
		// One short burst is held lit for the chosen stretch length
		for (int r = 0; r < 4; r++) begin
			modes(16'h000a, 16'h0010 | 16'(r << 8));
			@(posedge ref_clk_i);
			tx_act_i <= '1;
			@(posedge ref_clk_i);
			tx_act_i <= '0;
			count((2 * STR_MS[r] + 4) * MSC);
			check(96'(c0 >= STR_MS[r] * MSC && c0 <= (STR_MS[r] + 1) * MSC), 96'(1));
		end
		conclude();
	end
endmodule
`default_nettype wire
